// *** tsl_chan_sel.sv ***
// module: selected channel status to channel lamp drive
`timescale 1ns/1ps
`default_nettype none
module tsl_chan_sel
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire tsl_pkg::tsl_chan_in_type [tsl_pkg::CHAN_N-1:0] chans,
  input  wire logic [tsl_pkg::SEL_W-1:0]  sel,
  input  wire logic                       four_chan,
  output logic [tsl_pkg::SEL_W-1:0]       eff_sel,
  output tsl_pkg::tsl_chan_lamp_type      lamps
);

  tsl_pkg::tsl_chan_in_type c;

  // two-channel variant only reaches channels 0 and 1
  assign eff_sel = four_chan ? sel : {1'b0, sel[0]}; // RL12
  assign c       = chans[eff_sel]; // RL6

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lamps <= '0;
    else
    begin
      lamps.test <= c.lb_local | c.lb_remote | c.test_gen; // RL7
      lamps.chan_tx_space_lamp    <= c.tx_space; // RL8
      lamps.chan_rx_space_lamp    <= c.rx_space; // RL9
      lamps.chan_rts_lamp         <= c.rts; // RL10
      lamps.chan_data_detect_lamp <= c.data_detect; // RL11
    end
  end

endmodule // tsl_chan_sel
`default_nettype wire

// *** tsl_hold_timer.sv ***
// module: retriggerable hold timer that stretches a level
`timescale 1ns/1ps
`default_nettype none
module tsl_hold_timer
#(
  parameter int          W    = 26,
  parameter logic [W-1:0] HOLD = '1
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      active
);

  logic [W-1:0] cnt_r;

  // any trigger reloads, so the output ends HOLD cycles after the last
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (trig)
      cnt_r <= HOLD; // RL13
    else if (cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  assign active = (cnt_r != '0);

endmodule // tsl_hold_timer
`default_nettype wire

// *** tsl_pkg.sv ***
// package: constants and carrier types of the t1 status lamp block
package tsl_pkg;

  // timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int ALARM_HOLD_MS  = 500;
  localparam int ALARM_HOLD_CYC = ALARM_HOLD_MS * (CLK_HZ / 1000);
  localparam int HOLD_W         = 26;

  // channels
  localparam int CHAN_N = 4;
  localparam int SEL_W  = 2;

  // register map, byte addresses
  localparam int         ADDR_W       = 5;
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_STATUS   = 5'h04;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ_CLR  = 5'h0C;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h10;

  // field positions
  localparam int CTRL_SEL_LSB  = 0;
  localparam int STAT_NET_LSB  = 0;
  localparam int STAT_CHAN_LSB = 4;
  localparam int STAT_SEL_LSB  = 9;
  localparam int STAT_FOUR_BIT = 11;
  localparam int IRQ_ALARM     = 0;
  localparam int IRQ_SYNC_LOST = 1;
  localparam int IRQ_CARR_LOST = 2;
  localparam int IRQ_W         = 3;

  // reset values and answers
  localparam logic [1:0]  CTRL_SEL_RST = 2'h0;
  localparam logic [2:0]  IRQ_EN_RST   = 3'h0;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic agg_lb_local;
    logic agg_lb_remote;
    logic net_lb_local;
    logic net_lb_remote;
    logic lb_code_tx;
    logic carrier;
    logic sync;
    logic out_of_frame;
    logic bpv;
    logic yellow_rx;
    logic red_alarm;
  } tsl_net_in_type;

  typedef struct packed {
    logic lb_local;
    logic lb_remote;
    logic test_gen;
    logic tx_space;
    logic rx_space;
    logic rts;
    logic data_detect;
  } tsl_chan_in_type;

  typedef struct packed {
    logic alarm;
    logic sync;
    logic carrier;
    logic test;
  } tsl_net_lamp_type;

  typedef struct packed {
    logic chan_data_detect_lamp;
    logic chan_rts_lamp;
    logic chan_rx_space_lamp;
    logic chan_tx_space_lamp;
    logic test;
  } tsl_chan_lamp_type;

endpackage

// *** tsl_status_lamps.sv ***
// module: t1 mux front panel lamp logic with axi4-lite registers
//
// Summary of operation
// (RL1) Network test lamp lights in any aggregate or network loopback.
// (RL2) Network test lamp also lights while sending a loopback code.
// (RL3) Carrier lamp follows detected receive carrier on the line.
// (RL4) Sync lamp follows framer synchronisation with the remote unit.
// (RL5) Alarm lamp lights half a second on frame, bipolar or alarm fault.
// (RL6) Channel lamps show only the one operator-selected channel.
// (RL7) Channel test lamp lights in channel loopback or test generation.
// (RL8) Channel transmit lamp lights while transmit data is space.
// (RL9) Channel receive lamp lights while receive data is space.
// (RL10) Channel request-to-send lamp follows the channel RTS input.
// (RL11) Channel carrier-detect lamp follows the data-detect function.
// (RL12) Selector reaches four channels, or two on the small variant.
// (RL13) Alarm hold counter restarts on each alarm, ends after the last.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tsl_status_lamps
#(
  parameter int HOLD_CYCLES = tsl_pkg::ALARM_HOLD_CYC
)
(
  input  wire logic                         CLK,
  input  wire logic                         RESET_N,
  input  wire logic                         FOUR_CHAN_VARIANT,
  input  wire tsl_pkg::tsl_net_in_type      NET_IN,
  input  wire tsl_pkg::tsl_chan_in_type [tsl_pkg::CHAN_N-1:0] CHAN_IN,
  output tsl_pkg::tsl_net_lamp_type         NET_LAMPS,
  output tsl_pkg::tsl_chan_lamp_type        CHAN_LAMPS,
  output logic                              IRQ,
  input  wire logic [tsl_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                         S_AXI_AWVALID,
  output logic                              S_AXI_AWREADY,
  input  wire logic [31:0]                  S_AXI_WDATA,
  input  wire logic [3:0]                   S_AXI_WSTRB,
  input  wire logic                         S_AXI_WVALID,
  output logic                              S_AXI_WREADY,
  output logic [1:0]                        S_AXI_BRESP,
  output logic                              S_AXI_BVALID,
  input  wire logic                         S_AXI_BREADY,
  input  wire logic [tsl_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                         S_AXI_ARVALID,
  output logic                              S_AXI_ARREADY,
  output logic [31:0]                       S_AXI_RDATA,
  output logic [1:0]                        S_AXI_RRESP,
  output logic                              S_AXI_RVALID,
  input  wire logic                         S_AXI_RREADY
);

  localparam logic [tsl_pkg::HOLD_W-1:0] HOLD_LEN =
    tsl_pkg::HOLD_W'(HOLD_CYCLES);

  logic                            strap_done_r;
  logic                            four_chan_r;
  logic [tsl_pkg::SEL_W-1:0]       sel_r;
  logic [tsl_pkg::SEL_W-1:0]       eff_sel;
  logic                            net_test_r;
  logic                            net_carrier_r;
  logic                            net_sync_r;
  logic                            alarm_cond;
  logic                            alarm_lamp;
  logic                            alarm_q_r;
  logic                            sync_q_r;
  logic                            carr_q_r;
  logic [tsl_pkg::IRQ_W-1:0]       irq_ev;
  logic [tsl_pkg::IRQ_W-1:0]       irq_stat_r;
  logic [tsl_pkg::IRQ_W-1:0]       irq_en_r;
  logic [tsl_pkg::IRQ_W-1:0]       irq_clr;
  logic                            aw_done_r;
  logic                            w_done_r;
  logic [tsl_pkg::ADDR_W-1:0]      awaddr_r;
  logic [31:0]                     wdata_r;
  logic [3:0]                      wstrb_r;
  logic                            wr_go;
  logic [tsl_pkg::ADDR_W-1:0]      waddr;
  logic [tsl_pkg::ADDR_W-1:0]      raddr;
  logic                            wr_map;
  logic                            wr_ctrl;
  logic                            wr_clr;
  logic                            wr_en;
  logic                            rd_go;
  logic [31:0]                     rd_data;
  logic                            rd_map;
  logic [tsl_pkg::HOLD_W-1:0]      since_r;

  // variant strap is caught on the first clock after reset release
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      strap_done_r <= 1'b0;
      four_chan_r  <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      four_chan_r  <= FOUR_CHAN_VARIANT; // RL12
    end
  end

  // network lamps
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      net_test_r    <= 1'b0;
      net_carrier_r <= 1'b0;
      net_sync_r    <= 1'b0;
    end
    else
    begin
      net_test_r <= NET_IN.agg_lb_local | NET_IN.agg_lb_remote // RL1
                  | NET_IN.net_lb_local | NET_IN.net_lb_remote
                  | NET_IN.lb_code_tx; // RL2
      net_carrier_r <= NET_IN.carrier; // RL3
      net_sync_r    <= NET_IN.sync; // RL4
    end
  end

  assign alarm_cond = NET_IN.out_of_frame | NET_IN.bpv // RL5
                    | NET_IN.yellow_rx | NET_IN.red_alarm;

  tsl_hold_timer
  #(
    .W    (tsl_pkg::HOLD_W),
    .HOLD (HOLD_LEN)
  )
  u_alarm_hold
  (
    .clk    (CLK),
    .rst_n  (RESET_N),
    .trig   (alarm_cond),
    .active (alarm_lamp)
  );

  assign NET_LAMPS.test    = net_test_r;
  assign NET_LAMPS.carrier = net_carrier_r;
  assign NET_LAMPS.sync    = net_sync_r;
  assign NET_LAMPS.alarm   = alarm_lamp; // RL5

  tsl_chan_sel u_chan_sel
  (
    .clk       (CLK),
    .rst_n     (RESET_N),
    .chans     (CHAN_IN),
    .sel       (sel_r),
    .four_chan (four_chan_r),
    .eff_sel   (eff_sel),
    .lamps     (CHAN_LAMPS)
  );

  // interrupt events: alarm onset, loss of sync, loss of carrier
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      alarm_q_r <= 1'b0;
      sync_q_r  <= 1'b0;
      carr_q_r  <= 1'b0;
    end
    else
    begin
      alarm_q_r <= alarm_lamp;
      sync_q_r  <= NET_IN.sync;
      carr_q_r  <= NET_IN.carrier;
    end
  end

  assign irq_ev[tsl_pkg::IRQ_ALARM]     = alarm_lamp & ~alarm_q_r;
  assign irq_ev[tsl_pkg::IRQ_SYNC_LOST] = sync_q_r & ~NET_IN.sync;
  assign irq_ev[tsl_pkg::IRQ_CARR_LOST] = carr_q_r & ~NET_IN.carrier;
  assign irq_clr = wr_clr ? wdata_r[tsl_pkg::IRQ_W-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
  end

  assign IRQ = |(irq_stat_r & irq_en_r);

  // axi4-lite write: address and data taken in either order
  assign S_AXI_AWREADY = !aw_done_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_done_r && !S_AXI_BVALID;
  assign wr_go         = aw_done_r && w_done_r && !S_AXI_BVALID;
  assign waddr         = {awaddr_r[tsl_pkg::ADDR_W-1:2], 2'b00};

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_done_r <= 1'b0;
      awaddr_r  <= '0;
    end
    else if (wr_go)
      aw_done_r <= 1'b0;
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_done_r <= 1'b1;
      awaddr_r  <= S_AXI_AWADDR;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      w_done_r <= 1'b0;
      wdata_r  <= tsl_pkg::RDATA_ZERO;
      wstrb_r  <= 4'h0;
    end
    else if (wr_go)
      w_done_r <= 1'b0;
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_done_r <= 1'b1;
      wdata_r  <= S_AXI_WDATA;
      wstrb_r  <= S_AXI_WSTRB;
    end
  end

  // read-only registers accept writes silently
  assign wr_map = (waddr == tsl_pkg::OFS_CTRL)
               || (waddr == tsl_pkg::OFS_STATUS)
               || (waddr == tsl_pkg::OFS_IRQ_STAT)
               || (waddr == tsl_pkg::OFS_IRQ_CLR)
               || (waddr == tsl_pkg::OFS_IRQ_EN);
  assign wr_ctrl = wr_go && wstrb_r[0] && (waddr == tsl_pkg::OFS_CTRL);
  assign wr_clr  = wr_go && wstrb_r[0] && (waddr == tsl_pkg::OFS_IRQ_CLR);
  assign wr_en   = wr_go && wstrb_r[0] && (waddr == tsl_pkg::OFS_IRQ_EN);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= tsl_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_map ? tsl_pkg::RESP_OKAY : tsl_pkg::RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // the selector is stored as written; the variant clamp acts downstream
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      sel_r <= tsl_pkg::CTRL_SEL_RST;
    else if (wr_ctrl)
      sel_r <= wdata_r[tsl_pkg::CTRL_SEL_LSB +: tsl_pkg::SEL_W]; // RL6
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_en_r <= tsl_pkg::IRQ_EN_RST;
    else if (wr_en)
      irq_en_r <= wdata_r[tsl_pkg::IRQ_W-1:0];
  end

  // axi4-lite read: one cycle from address to data
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_go         = S_AXI_ARVALID && S_AXI_ARREADY;
  assign raddr         = {S_AXI_ARADDR[tsl_pkg::ADDR_W-1:2], 2'b00};

  always_comb
  begin
    rd_data = tsl_pkg::RDATA_ZERO;
    rd_map  = 1'b1;
    unique case (raddr)
      tsl_pkg::OFS_CTRL:
        rd_data[tsl_pkg::CTRL_SEL_LSB +: tsl_pkg::SEL_W] = sel_r;
      tsl_pkg::OFS_STATUS:
      begin
        rd_data[tsl_pkg::STAT_NET_LSB +: 4]  = NET_LAMPS;
        rd_data[tsl_pkg::STAT_CHAN_LSB +: 5] = CHAN_LAMPS;
        rd_data[tsl_pkg::STAT_SEL_LSB +: tsl_pkg::SEL_W] = eff_sel;
        rd_data[tsl_pkg::STAT_FOUR_BIT]      = four_chan_r;
      end
      tsl_pkg::OFS_IRQ_STAT:
        rd_data[tsl_pkg::IRQ_W-1:0] = irq_stat_r;
      tsl_pkg::OFS_IRQ_EN:
        rd_data[tsl_pkg::IRQ_W-1:0] = irq_en_r;
      tsl_pkg::OFS_IRQ_CLR:
        rd_data = tsl_pkg::RDATA_ZERO;
      default:
        rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= tsl_pkg::RDATA_ZERO;
      S_AXI_RRESP  <= tsl_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_data;
      S_AXI_RRESP  <= rd_map ? tsl_pkg::RESP_OKAY : tsl_pkg::RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

  // helper: cycles since the last alarm condition, saturating
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      since_r <= '1;
    else if (alarm_cond)
      since_r <= tsl_pkg::HOLD_W'(1);
    else if (since_r != '1)
      since_r <= since_r + tsl_pkg::HOLD_W'(1);
  end

  sequence s_loop_req;
    NET_IN.agg_lb_local || NET_IN.agg_lb_remote || NET_IN.net_lb_local
    || NET_IN.net_lb_remote || NET_IN.lb_code_tx;
  endsequence

  sequence s_wr_ready;
    aw_done_r && w_done_r && !S_AXI_BVALID;
  endsequence

  sequence s_wr_answer;
    S_AXI_BVALID [*1] ##0 !S_AXI_AWREADY && !S_AXI_WREADY;
  endsequence

  a_net_test_on: assert property ( // RL1
    @(posedge CLK) disable iff (!RESET_N)
    s_loop_req |=> NET_LAMPS.test)
    else $error("network test lamp missed a loopback state");

  a_net_test_off: assert property ( // RL2
    @(posedge CLK) disable iff (!RESET_N)
    !(NET_IN.agg_lb_local || NET_IN.agg_lb_remote || NET_IN.net_lb_local
      || NET_IN.net_lb_remote || NET_IN.lb_code_tx) |=> !NET_LAMPS.test)
    else $error("network test lamp lit with no test state");

  a_carrier_lamp: assert property ( // RL3
    @(posedge CLK) disable iff (!RESET_N)
    ##1 NET_LAMPS.carrier == $past(NET_IN.carrier))
    else $error("carrier lamp does not follow carrier");

  a_sync_lamp: assert property ( // RL4
    @(posedge CLK) disable iff (!RESET_N)
    $fell(NET_IN.sync) |=> !NET_LAMPS.sync ##0 $past(NET_LAMPS.sync))
    else $error("sync lamp did not drop on loss of sync");

  a_alarm_hold: assert property ( // RL5
    @(posedge CLK) disable iff (!RESET_N)
    NET_LAMPS.alarm == (since_r <= HOLD_LEN))
    else $error("alarm lamp hold length wrong");

  a_alarm_restart: assert property ( // RL13
    @(posedge CLK) disable iff (!RESET_N)
    alarm_cond |=> NET_LAMPS.alarm [*2])
    else $error("alarm lamp not restarted by alarm");

  a_chan_rts: assert property ( // RL10
    @(posedge CLK) disable iff (!RESET_N)
    ##1 CHAN_LAMPS.chan_rts_lamp == $past(CHAN_IN[eff_sel].rts))
    else $error("rts lamp shows the wrong channel");

  a_chan_detect: assert property ( // RL11
    @(posedge CLK) disable iff (!RESET_N)
    ##1 CHAN_LAMPS.chan_data_detect_lamp
      == $past(CHAN_IN[eff_sel].data_detect))
    else $error("data detect lamp shows the wrong channel");

  a_chan_test: assert property ( // RL7
    @(posedge CLK) disable iff (!RESET_N)
    CHAN_IN[eff_sel].test_gen && $stable(eff_sel) |=> CHAN_LAMPS.test)
    else $error("channel test lamp missed test generation");

  a_chan_space: assert property ( // RL8
    @(posedge CLK) disable iff (!RESET_N)
    ##1 CHAN_LAMPS.chan_tx_space_lamp == $past(CHAN_IN[eff_sel].tx_space)
     && CHAN_LAMPS.chan_rx_space_lamp == $past(CHAN_IN[eff_sel].rx_space))
    else $error("space lamps show the wrong channel"); // RL9

  a_two_chan_sel: assert property ( // RL12
    @(posedge CLK) disable iff (!RESET_N)
    strap_done_r && !four_chan_r |-> eff_sel[1] == 1'b0)
    else $error("two-channel variant selected channel above two");

  a_sel_write: assert property ( // RL6
    @(posedge CLK) disable iff (!RESET_N)
    wr_ctrl && four_chan_r |=> eff_sel == $past(wdata_r[1:0]))
    else $error("channel selector write not applied");

  a_irq_set_wins: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    irq_ev[tsl_pkg::IRQ_ALARM] |=> irq_stat_r[tsl_pkg::IRQ_ALARM])
    else $error("alarm event lost");

  a_wr_answer: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    s_wr_ready |=> s_wr_answer)
    else $error("write response not given one cycle after both halves");

endmodule // tsl_status_lamps
`default_nettype wire

// *** tsl_status_lamps_bench.sv ***
// testbench: lamp drive, alarm hold, channel select and register bus
`timescale 1ns/1ps
`default_nettype none
module tsl_status_lamps_bench;
  // short hold so the alarm stretch fits the run
  localparam int H = 20;
  logic                       clk;
  logic                       rst_n;
  logic                       four;
  tsl_pkg::tsl_net_in_type    net_cmd;
  tsl_pkg::tsl_net_in_type    net;
  tsl_pkg::tsl_chan_in_type [3:0] chan_cmd;
  tsl_pkg::tsl_chan_in_type [3:0] chan;
  tsl_pkg::tsl_net_lamp_type  net_lamps;
  tsl_pkg::tsl_chan_lamp_type chan_lamps;
  logic                       irq;
  logic [4:0]                 awaddr;
  logic [4:0]                 araddr;
  logic [31:0]                wdata;
  logic [3:0]                 wstrb;
  logic [31:0]                rdata;
  logic [1:0]                 bresp;
  logic [1:0]                 rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int                         miscompares;
  int                         tests_run;

  tsl_status_src u_src (.clk(clk), .rst_n(rst_n), .net_cmd(net_cmd),
    .chan_cmd(chan_cmd), .net(net), .chan(chan));

  tsl_status_lamps #(.HOLD_CYCLES(H)) u_dut (
    .CLK(clk), .RESET_N(rst_n), .FOUR_CHAN_VARIANT(four),
    .NET_IN(net), .CHAN_IN(chan), .NET_LAMPS(net_lamps),
    .CHAN_LAMPS(chan_lamps), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  task automatic end_of_test();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready is sampled at the negedge: inputs only move at posedges
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int   n;
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 50 && !tb; n++)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb)
        cmp("bresp", 32'(er), 32'(bresp));
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] er);
    int   n;
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 50 && !tr; n++)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      if (tr)
      begin
        cmp("rdata", e, rdata & m);
        cmp("rresp", 32'(er), 32'(rresp));
      end
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tr)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_reset_vals();
    cmp("net lamps", 0, 32'(net_lamps));
    cmp("irq", 0, 32'(irq));
    rd(tsl_pkg::OFS_CTRL, '1, 0, tsl_pkg::RESP_OKAY);
    rd(tsl_pkg::OFS_IRQ_EN, '1, 0, tsl_pkg::RESP_OKAY);
    rd(tsl_pkg::OFS_IRQ_STAT, '1, 0, tsl_pkg::RESP_OKAY);
  endtask

  task automatic t_net();
    int i;
    int e;
    for (i = 4; i < 11; i++)
    begin
      @(posedge clk);
      net_cmd <= 11'h001 << i;
      settle();
      e = (i > 5) ? 1 : (i == 5) ? 2 : 4;
      cmp("net lamps", e, 32'(net_lamps));
    end
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    net_cmd <= 11'h001 << i;
    @(posedge clk);
    net_cmd <= '0;
  endtask

  task automatic hold_ends();
    repeat (H) @(posedge clk);
    @(negedge clk);
    cmp("alarm lamp", 1, 32'(net_lamps.alarm));
    @(negedge clk);
    cmp("alarm lamp", 0, 32'(net_lamps.alarm));
  endtask

  task automatic t_alarm();
    int i;
    for (i = 0; i < 4; i++)
    begin
      pulse(i);
      hold_ends();
    end
    // a second fault inside the hold must push the end out
    pulse(2);
    repeat (8) @(posedge clk);
    pulse(2);
    hold_ends();
  endtask

  task automatic t_chan();
    int             c, f;
    logic [3:0][6:0] v;
    logic [31:0]     e;
    for (c = 0; c < 4; c++)
    begin
      wr(tsl_pkg::OFS_CTRL, 32'(c), tsl_pkg::RESP_OKAY);
      e = 32'h0000_0800 | (32'(c) << tsl_pkg::STAT_SEL_LSB);
      rd(tsl_pkg::OFS_STATUS, 32'h0000_0E00, e, 0);
      for (f = 0; f < 7; f++)
      begin
        v = {4{7'h7F}};
        v[c] = 7'h01 << f;
        @(posedge clk);
        chan_cmd <= v;
        settle();
        e = (f > 3) ? 1 : 16 >> f;
        cmp("chan lamps", e, 32'(chan_lamps));
      end
    end
  endtask

  task automatic t_irq();
    pulse(5);
    @(posedge clk);
    net_cmd <= 11'h020;
    settle();
    // alarm onset, sync loss and carrier loss have all happened by now
    rd(tsl_pkg::OFS_IRQ_STAT, '1, 32'h0000_0007, 0);
    wr(tsl_pkg::OFS_IRQ_CLR, 32'h0000_0007, 0);
    wr(tsl_pkg::OFS_IRQ_EN, 32'h0000_0004, 0);
    cmp("irq", 0, 32'(irq));
    rd(tsl_pkg::OFS_IRQ_EN, '1, 32'h0000_0004, 0);
    @(posedge clk);
    net_cmd <= '0;
    settle();
    cmp("irq", 1, 32'(irq));
    rd(tsl_pkg::OFS_IRQ_STAT, '1, 32'h0000_0004, 0);
    wr(tsl_pkg::OFS_IRQ_EN, 0, 0);
    cmp("irq", 0, 32'(irq));
    wr(tsl_pkg::OFS_IRQ_EN, 32'h0000_0004, 0);
    cmp("irq", 1, 32'(irq));
    wr(tsl_pkg::OFS_IRQ_CLR, 32'h0000_0004, 0);
    cmp("irq", 0, 32'(irq));
    rd(tsl_pkg::OFS_IRQ_CLR, '1, 0, 0);
    rd(5'h14, '1, 0, tsl_pkg::RESP_SLVERR);
    wr(5'h18, 32'h0000_0001, tsl_pkg::RESP_SLVERR);
  endtask

  task automatic t_two();
    @(posedge clk);
    four <= 1'b0;
    do_reset();
    repeat (2) @(posedge clk);
    wr(tsl_pkg::OFS_CTRL, 32'h0000_0003, 0);
    @(posedge clk);
    chan_cmd <= {7'h7F, 7'h7F, 7'h02, 7'h7F};
    settle();
    cmp("chan lamps", 32'h0000_0008, 32'(chan_lamps));
    rd(tsl_pkg::OFS_STATUS, 32'h0000_0E00, 32'h0000_0200, 0);
    // a write without its low strobe and a write to status change nothing
    wstrb <= 4'h0;
    wr(tsl_pkg::OFS_CTRL, 32'h0000_0000, 0);
    wstrb <= 4'hF;
    wr(tsl_pkg::OFS_STATUS, 32'h0000_0FFF, 0);
    rd(tsl_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_0003, 0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    four = 1'b1;
    net_cmd = '0;
    chan_cmd = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    do_reset();
    t_reset_vals();
    t_net();
    t_alarm();
    t_chan();
    t_irq();
    t_two();
    end_of_test();
  end
endmodule // tsl_status_lamps_bench
`default_nettype wire

// *** tsl_status_src.sv ***
// status source model: framer, loopback and channel interface levels
`timescale 1ns/1ps
`default_nettype none
module tsl_status_src
(
  input  wire logic                                          clk,
  input  wire logic                                          rst_n,
  input  wire tsl_pkg::tsl_net_in_type                       net_cmd,
  input  wire tsl_pkg::tsl_chan_in_type [tsl_pkg::CHAN_N-1:0] chan_cmd,
  output tsl_pkg::tsl_net_in_type                            net,
  output tsl_pkg::tsl_chan_in_type [tsl_pkg::CHAN_N-1:0]      chan
);
  // levels move one edge after the request, like a framer output register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      net  <= '0;
      chan <= '0;
    end
    else
    begin
      net  <= net_cmd;
      chan <= chan_cmd;
    end
  end
endmodule // tsl_status_src
`default_nettype wire
